/* File: src/css_sideband_ctrl.sv */
// Processor sideband control: purge, inquire answers, bus hold, numeric error, restart, interrupt.
`timescale 1ns/1ps
`include "css_consts.svh"
module css_sideband_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`CSS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CSS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cachePurgeN,
  input wire logic warmRestart,
  input wire logic maskableIrq,
  input wire logic mgmtIrqN,
  input wire logic nonmaskIrq,
  input wire logic ignoreNumericErrorN,
  input wire logic busTakeoverRequest,
  input wire logic snoopStrobeN,
  input wire logic transferReadyN,
  input wire logic lookupHit,
  input wire logic lookupModified,
  input wire logic lookupWbBusy,
  input wire logic wbCycleActive,
  input wire logic lastBeat,
  input wire logic cycleInProgress,
  input wire logic lockSeqBusy,
  input wire logic lockMore,
  input wire logic insnBoundary,
  input wire logic wbAllDone,
  input wire logic invalDone,
  input wire logic fackDone,
  input wire logic fpTargetValid,
  input wire logic fpExcPending,
  input wire logic fpErrSensitive,
  input wire logic iackDone,
  input wire logic [7:0] iackVector,
  output logic floatTestMode,
  output logic snoopMatchN,
  output logic snoopMatchOe,
  output logic snoopDirtyMatchN,
  output logic snoopDirtyOe,
  output logic snoopWbReq,
  output logic holdAck,
  output logic holdAckOe,
  output logic busFloat,
  output logic wbAllReq,
  output logic invalReq,
  output logic fackReq,
  output logic restartTake,
  output logic [27:0] restartFetchAddr,
  output logic iackReq,
  output logic [7:0] isrVector,
  output logic isrJump,
  output logic fpStall,
  output logic fpProceed,
  output logic fpVector10,
  output logic fpIrqBreak,
  output logic cacheDisableBit,
  output logic noWritethroughBit
);
  css_reg_if regBus ();

  logic floatTest_r, floatTest_nxt;
  logic purgePrev_r, purgePrev_nxt, purgeLatched_r, purgeLatched_nxt;
  logic warmPrev_r, warmPrev_nxt, warmLatched_r, warmLatched_nxt;
  css_pkg::css_purge_t purgeState_r, purgeState_nxt;
  logic snoopMatch_r, snoopMatch_nxt, dirty_r, dirty_nxt, snoopWb_r, snoopWb_nxt;
  logic holdAck_r, holdAck_nxt;
  logic [3:0] ctrl_r, ctrl_nxt;
  logic iackBusy_r, iackBusy_nxt, isrJump_r, isrJump_nxt, restart_r, restart_nxt;
  logic [7:0] vector_r, vector_nxt;
  logic fpStall_r, fpStall_nxt, fpProceed_r, fpProceed_nxt;
  logic fpVec_r, fpVec_nxt, fpBreak_r, fpBreak_nxt;
  logic snoopSample, finalBeat, boundaryFree, purgeTake, warmTake, irqTake, fpWake;

  // Bus slave in front of the register file.
  css_axil_slave u_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regBus.bus)
  );

  // Shared decode terms.
  assign finalBeat = ~transferReadyN & lastBeat;
  assign snoopSample = ~snoopStrobeN & ~dirty_r & ~floatTest_r;
  assign boundaryFree = insnBoundary & (purgeState_r == css_pkg::PG_IDLE) & ~iackBusy_r;
  assign purgeTake = boundaryFree & purgeLatched_r;
  assign warmTake = boundaryFree & ~purgeLatched_r & warmLatched_r;
  assign irqTake = boundaryFree & ~purgeLatched_r & ~warmLatched_r & maskableIrq
    & ctrl_r[`CSS_CTRL_IE];

  // Reset strap and edge latches for purge and warm restart; a new edge beats the take.
  // The edge trackers follow the pins through reset, so a level held across reset is no edge.
  always_comb begin
    floatTest_nxt = floatTest_r;
    purgePrev_nxt = cachePurgeN;
    warmPrev_nxt = warmRestart;
    purgeLatched_nxt = (purgeLatched_r & ~purgeTake) | (purgePrev_r & ~cachePurgeN);
    warmLatched_nxt = (warmLatched_r & ~warmTake) | (~warmPrev_r & warmRestart);
    if (rst) begin
      floatTest_nxt = ~cachePurgeN;
      purgeLatched_nxt = 1'b0;
      warmLatched_nxt = 1'b0;
    end
  end

  // The strap keeps the last level seen while reset is high.
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      floatTest_r <= floatTest_nxt;
      purgePrev_r <= purgePrev_nxt;
      warmPrev_r <= warmPrev_nxt;
      purgeLatched_r <= purgeLatched_nxt;
      warmLatched_r <= warmLatched_nxt;
    end
  end

  // Purge sequence: write back dirty lines, invalidate all, then flush acknowledge cycle.
  always_comb begin
    purgeState_nxt = purgeState_r;
    unique case (purgeState_r)
      css_pkg::PG_IDLE: begin
        if (purgeTake) begin
          purgeState_nxt = css_pkg::PG_WBACK;
        end
      end
      css_pkg::PG_WBACK: begin
        if (wbAllDone) begin
          purgeState_nxt = css_pkg::PG_INVAL;
        end
      end
      css_pkg::PG_INVAL: begin
        if (invalDone) begin
          purgeState_nxt = css_pkg::PG_FACK;
        end
      end
      css_pkg::PG_FACK: begin
        if (fackDone) begin
          purgeState_nxt = css_pkg::PG_IDLE;
        end
      end
    endcase
  end

  // Purge state register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      purgeState_r <= css_pkg::PG_IDLE;
    end else if (ce) begin
      purgeState_r <= purgeState_nxt;
    end
  end

  // Inquire answers are set on the edge after the strobe and dirty clears after the final ready; dirty blocks new strobes.
  always_comb begin
    snoopMatch_nxt = snoopMatch_r;
    dirty_nxt = dirty_r;
    snoopWb_nxt = 1'b0;
    if (snoopSample) begin
      snoopMatch_nxt = lookupHit;
      dirty_nxt = lookupModified;
      snoopWb_nxt = lookupModified & ~lookupWbBusy;
    end else if (dirty_r & wbCycleActive & finalBeat) begin
      dirty_nxt = 1'b0;
    end
  end

  // Inquire answer registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snoopMatch_r <= 1'b0;
      dirty_r <= 1'b0;
      snoopWb_r <= 1'b0;
    end else if (ce) begin
      snoopMatch_r <= snoopMatch_nxt;
      dirty_r <= dirty_nxt;
      snoopWb_r <= snoopWb_nxt;
    end
  end

  // Bus hold: grant when idle or after a final ready, never inside a locked run.
  always_comb begin
    holdAck_nxt = 1'b0;
    if (busTakeoverRequest) begin
      if (holdAck_r | rst) begin
        holdAck_nxt = 1'b1;
      end else if (~cycleInProgress & ~lockSeqBusy) begin
        holdAck_nxt = 1'b1;
      end else if (finalBeat & ~lockMore) begin
        holdAck_nxt = 1'b1;
      end
    end
  end

  // Hold acknowledge register; it also runs through reset.
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      holdAck_r <= holdAck_nxt;
    end
  end

  // Control register writes; a warm restart clears the flags but keeps cache control.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (regBus.wrEn && regBus.wrAddr == `CSS_OFS_CTRL && regBus.wrStrb[0]) begin
      ctrl_nxt = regBus.wrData[3:0];
    end
    if (warmTake) begin
      ctrl_nxt[`CSS_CTRL_NE] = 1'b0;
      ctrl_nxt[`CSS_CTRL_IE] = 1'b0;
    end
  end

  // Control register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= `CSS_CTRL_RST;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Register read decode and status word.
  always_comb begin
    regBus.wrOk = (regBus.wrAddr == `CSS_OFS_CTRL) || (regBus.wrAddr == `CSS_OFS_STAT);
    regBus.rdOk = 1'b1;
    regBus.rdData = 32'h0000_0000;
    if (regBus.rdAddr == `CSS_OFS_CTRL) begin
      regBus.rdData = {28'h0000000, ctrl_r};
    end else if (regBus.rdAddr == `CSS_OFS_STAT) begin
      regBus.rdData = {16'h0000, vector_r, 1'b0, purgeState_r, fpStall_r, holdAck_r,
        warmLatched_r, purgeLatched_r, floatTest_r};
    end else begin
      regBus.rdOk = 1'b0;
    end
  end

  // Restart pulse and interrupt acknowledge handshake with vector capture.
  always_comb begin
    restart_nxt = warmTake;
    iackBusy_nxt = iackBusy_r;
    isrJump_nxt = 1'b0;
    vector_nxt = vector_r;
    if (irqTake) begin
      iackBusy_nxt = 1'b1;
    end else if (iackBusy_r & iackDone) begin
      iackBusy_nxt = 1'b0;
      isrJump_nxt = 1'b1;
      vector_nxt = iackVector;
    end
  end

  // Restart and interrupt registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      restart_r <= 1'b0;
      iackBusy_r <= 1'b0;
      isrJump_r <= 1'b0;
      vector_r <= 8'h00;
    end else if (ce) begin
      restart_r <= restart_nxt;
      iackBusy_r <= iackBusy_nxt;
      isrJump_r <= isrJump_nxt;
      vector_r <= vector_nxt;
    end
  end

  // Numeric error decision for a target instruction, sampled as levels every edge.
  assign fpWake = maskableIrq | ~mgmtIrqN | nonmaskIrq | warmRestart;
  always_comb begin
    fpProceed_nxt = 1'b0;
    fpVec_nxt = 1'b0;
    fpBreak_nxt = 1'b0;
    fpStall_nxt = 1'b0;
    if (fpTargetValid) begin
      if (~fpExcPending | ~fpErrSensitive) begin
        fpProceed_nxt = 1'b1;
      end else if (ctrl_r[`CSS_CTRL_NE]) begin
        fpVec_nxt = 1'b1;
      end else if (~ignoreNumericErrorN) begin
        fpProceed_nxt = 1'b1;
      end else if (fpWake) begin
        fpBreak_nxt = 1'b1;
      end else begin
        fpStall_nxt = 1'b1;
      end
    end
  end

  // Numeric error decision registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fpProceed_r <= 1'b0;
      fpVec_r <= 1'b0;
      fpBreak_r <= 1'b0;
      fpStall_r <= 1'b0;
    end else if (ce) begin
      fpProceed_r <= fpProceed_nxt;
      fpVec_r <= fpVec_nxt;
      fpBreak_r <= fpBreak_nxt;
      fpStall_r <= fpStall_nxt;
    end
  end

  // Pin drivers; the match, dirty match and hold acknowledge drivers are released in float test mode.
  assign floatTestMode = floatTest_r;
  assign snoopMatchN = ~snoopMatch_r;
  assign snoopMatchOe = ~floatTest_r;
  assign snoopDirtyMatchN = ~dirty_r;
  assign snoopDirtyOe = ~floatTest_r;
  assign snoopWbReq = snoopWb_r;
  assign holdAck = holdAck_r;
  assign holdAckOe = ~floatTest_r;
  assign busFloat = holdAck_r | floatTest_r;
  assign wbAllReq = (purgeState_r == css_pkg::PG_WBACK);
  assign invalReq = (purgeState_r == css_pkg::PG_INVAL);
  assign fackReq = (purgeState_r == css_pkg::PG_FACK);
  assign restartTake = restart_r;
  assign restartFetchAddr = `CSS_RESET_START;
  assign iackReq = iackBusy_r;
  assign isrVector = vector_r;
  assign isrJump = isrJump_r;
  assign fpStall = fpStall_r;
  assign fpProceed = fpProceed_r;
  assign fpVector10 = fpVec_r;
  assign fpIrqBreak = fpBreak_r;
  assign cacheDisableBit = ctrl_r[`CSS_CTRL_CD];
  assign noWritethroughBit = ctrl_r[`CSS_CTRL_NW];

  // Checks on the timing of the sideband outputs.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_purge_order: assert property (
    ce && purgeState_r == css_pkg::PG_WBACK && wbAllDone |=> purgeState_r == css_pkg::PG_INVAL)
    else $error("purge did not move from writeback to invalidate");
  a_snoop_hit_time: assert property (
    ce && snoopSample |=> snoopMatchN == !$past(lookupHit))
    else $error("snoop match not driven on the edge after the strobe");
  a_snoop_level_hold: assert property (
    ce && snoopStrobeN |=> $stable(snoopMatchN))
    else $error("snoop match changed without a strobe");
  a_dirty_wb_req: assert property (
    ce && snoopSample && lookupModified
    |=> !snoopDirtyMatchN && (snoopWbReq == !$past(lookupWbBusy)))
    else $error("dirty match or writeback request wrong after a modified hit");
  a_dirty_release: assert property (
    ce && !snoopDirtyMatchN && wbCycleActive && finalBeat && snoopStrobeN |=> snoopDirtyMatchN)
    else $error("dirty match not negated after the final ready");
  a_hold_idle_grant: assert property (
    ce && busTakeoverRequest && !cycleInProgress && !lockSeqBusy |=> holdAck)
    else $error("hold not acknowledged one edge after request on idle bus");
  a_hold_lock_wait: assert property (
    ce && !holdAck && lockSeqBusy && !(finalBeat && !lockMore) |=> !holdAck)
    else $error("hold granted inside a locked sequence");
  a_hold_floats_bus: assert property (
    holdAck |-> busFloat)
    else $error("bus not floated while hold is acknowledged");
  a_hold_release: assert property (
    ce && !busTakeoverRequest |=> !holdAck)
    else $error("hold acknowledge not negated one edge after request dropped");
  a_numerr_vector: assert property (
    ce && fpTargetValid && fpExcPending && fpErrSensitive && ctrl_r[`CSS_CTRL_NE]
    |=> fpVector10 && !fpProceed)
    else $error("numeric error handler not raised with enable set");
  a_boundary_prio: assert property (
    ce && purgeTake |=> purgeState_r == css_pkg::PG_WBACK && !restartTake && !iackReq)
    else $error("purge did not win at the instruction boundary");
endmodule // css_sideband_ctrl

/* File: pkg/css_consts.svh */
// Constants for the processor sideband control block.
// Contract
// - A recognized purge writes back dirty lines, invalidates caches, then runs flush acknowledge.
// - Purge input low while reset falls selects float test mode instead of normal start.
// - Purge input latched on a falling edge each clock, acted on at instruction boundary.
// - Reset-time purge level is taken on the edge before reset is seen negated.
// - Match output driven except in float test, changes only after strobe, then holds.
// - Inquire hit on a modified line asserts dirty match and requests a writeback.
// - Hit on a line already being written back asserts dirty match without new writeback.
// - Dirty match drives after strobe, holds, and negates one edge after final transfer ready.
// - Bus takeover checked each edge; acknowledge after one edge idle, or after final ready.
// - Hold acknowledge never granted inside a locked sequence of bus cycles.
// - Every clock with hold acknowledge asserted, the bus outputs are floated.
// - Hold acknowledge negates one edge after takeover request is sampled negated.
// - Hold acknowledge ignores backoff and is glitch free, driven except in float test.
// - Takeover request is honoured while warm restart or system reset is asserted.
// - Enable clear: ignore input proceeds, else stall until ignore or an interrupt arrives.
// - Enable set raises vector 10h handler; error-insensitive targets simply continue.
// - Ignore input sampled as a level every edge; asynchronous pulses last two clocks.
// - Warm restart refetches from start address, keeping caches and cache control bits.
// - Warm restart latched on rising edge, taken at boundary; three edges before ready.
// - Maskable interrupt with flag set runs interrupt acknowledge, then jumps to vector.
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
`define CSS_ADDR_W 8
`define CSS_OFS_CTRL 8'h00
`define CSS_OFS_STAT 8'h04
`define CSS_CTRL_NE 0
`define CSS_CTRL_IE 1
`define CSS_CTRL_CD 2
`define CSS_CTRL_NW 3
`define CSS_CTRL_RST 4'h0
`define CSS_RESET_START 28'hFFFFFF0
`define CSS_VEC_NUMERR 8'h10
`define CSS_RESP_OKAY 2'h0
`define CSS_RESP_SLVERR 2'h2
`endif

/* File: pkg/css_pkg.sv */
// Types shared by the sideband control block.
package css_pkg;
  // Cache purge sequence, Gray coded along its path.
  typedef enum logic [1:0] {
    PG_IDLE = 2'h0,
    PG_WBACK = 2'h1,
    PG_INVAL = 2'h3,
    PG_FACK = 2'h2
  } css_purge_t;
endpackage

/* File: pkg/css_reg_if.sv */
// Register access path between the bus slave and the control core.
`timescale 1ns/1ps
`include "css_consts.svh"
interface css_reg_if;
  logic wrEn;
  logic [`CSS_ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrOk;
  logic [`CSS_ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic rdOk;
  modport bus (output wrEn, wrAddr, wrData, wrStrb, rdAddr, input wrOk, rdData, rdOk);
  modport regs (input wrEn, wrAddr, wrData, wrStrb, rdAddr, output wrOk, rdData, rdOk);
endinterface

/* File: src/css_axil_slave.sv */
// AXI4-Lite slave that turns bus transfers into register accesses.
`timescale 1ns/1ps
`include "css_consts.svh"
module css_axil_slave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`CSS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CSS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  css_reg_if.bus regs
);
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wrTake, rdTake;

  // Address and data are taken together, only while no response is waiting.
  assign wrTake = ce & s_axi_awvalid & s_axi_wvalid & ~bvalid_r & ~rst;
  assign rdTake = ce & s_axi_arvalid & ~rvalid_r & ~rst;
  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign s_axi_arready = rdTake;
  assign regs.wrEn = wrTake;
  assign regs.wrAddr = s_axi_awaddr;
  assign regs.wrData = s_axi_wdata;
  assign regs.wrStrb = s_axi_wstrb;
  assign regs.rdAddr = s_axi_araddr;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Response channels hold until the master accepts them.
  always_comb begin
    bvalid_nxt = bvalid_r & ~s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r & ~s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (wrTake) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = regs.wrOk ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
    end
    if (rdTake) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = regs.rdOk ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
      rdata_nxt = regs.rdOk ? regs.rdData : 32'h0000_0000;
    end
  end

  // Response registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= `CSS_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `CSS_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
endmodule // css_axil_slave

/* File: sim/css_chipset_model.sv */
// Chipset-side model that drives purge, restart, interrupt and bus takeover requests.
`timescale 1ns/1ps
module css_chipset_model (
  input wire logic ref_clk,
  input wire logic doPurge,
  input wire logic doWarm,
  input wire logic doIrq,
  input wire logic doHold,
  input wire logic iackDone,
  output logic cachePurgeN,
  output logic warmRestart,
  output logic maskableIrq,
  output logic busTakeoverRequest
);
  // All requests start negated so the strap sees a plain start.
  initial begin
    cachePurgeN = 1'b1;
    warmRestart = 1'b0;
    maskableIrq = 1'b0;
    busTakeoverRequest = 1'b0;
  end
  // Requests change just after an edge and last as long as the command does, except the interrupt, which holds until iackDone.
  always @(posedge ref_clk) begin
    cachePurgeN <= ~doPurge;
    warmRestart <= doWarm;
    busTakeoverRequest <= doHold;
    if (doIrq)
      maskableIrq <= 1'b1;
    else if (iackDone)
      maskableIrq <= 1'b0;
  end
endmodule // css_chipset_model

/* File: sim/tb_top.sv */
// Self-checking bench for the processor sideband control block.
`timescale 1ns/1ps
`include "css_consts.svh"
module tb_top;
  logic rst = 1'b1, ce = 1'b1, ref_clk, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [`CSS_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cachePurgeN, warmRestart, maskableIrq, busTakeoverRequest, wbAllDone, invalDone, fackDone;
  logic mgmtIrqN = 1'b1, nonmaskIrq = 1'b0, ignoreNumericErrorN = 1'b1, snoopStrobeN = 1'b1;
  logic transferReadyN = 1'b1, lookupHit = 1'b0, lookupModified = 1'b0, lookupWbBusy = 1'b0;
  logic wbCycleActive = 1'b0, lastBeat = 1'b0, cycleInProgress = 1'b0, lockSeqBusy = 1'b0;
  logic lockMore = 1'b0, insnBoundary = 1'b0, fpTargetValid = 1'b0, fpExcPending = 1'b0;
  logic fpErrSensitive = 1'b0, iackDone = 1'b0, doPurge = 1'b0, doWarm = 1'b0;
  logic doIrq = 1'b0, doHold = 1'b0;
  logic [2:0] doneV = 3'h0;
  logic [7:0] iackVector = 8'h00, isrVector;
  logic [27:0] restartFetchAddr;
  logic floatTestMode, snoopMatchN, snoopMatchOe, snoopDirtyMatchN, snoopDirtyOe, snoopWbReq;
  logic holdAck, holdAckOe, busFloat, wbAllReq, invalReq, fackReq, restartTake, iackReq;
  logic isrJump, fpStall, fpProceed, fpVector10, fpIrqBreak, cacheDisableBit, noWritethroughBit;
  int n_mismatch, num_checks, cycles;
  assign {fackDone, invalDone, wbAllDone} = doneV;
  css_sideband_ctrl i_css_sideband_ctrl (.*);
  css_chipset_model i_css_chipset_model (.*);
  // The clock toggles every half period of 2.5 ns.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // A run that hangs is cut short and reported as a mismatch.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One instruction boundary pulse, then let its edge land.
  task automatic boundary;
    @(posedge ref_clk);
    insnBoundary <= 1'b1;
    @(posedge ref_clk);
    insnBoundary <= 1'b0;
    #1;
  endtask
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Main sequence of tests.
  initial begin
    cyc(3);
    rst <= 1'b0;
    #1;
    chk("floatTestMode", 0, floatTestMode);
    axWrite(`CSS_OFS_CTRL, 32'h0000000C, resp);
    chk("bresp", `CSS_RESP_OKAY, resp);
    axRead(`CSS_OFS_CTRL, rd, resp);
    chk("ctrl", 32'h0000000C, rd);
    chk("cacheDisableBit", 1, cacheDisableBit);
    axRead(8'h08, rd, resp);
    chk("unmapped resp", `CSS_RESP_SLVERR, resp);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      snoopStrobeN <= 1'b0;
      lookupHit <= 1'b1;
      lookupModified <= m[0];
      @(posedge ref_clk);
      snoopStrobeN <= 1'b1;
      #1;
      chk("snoopMatchN", 0, snoopMatchN);
      chk("snoopDirtyMatchN", (m == 0), snoopDirtyMatchN);
      chk("snoopWbReq", (m == 1), snoopWbReq);
    end
    cyc(3);
    #1;
    chk("snoopMatchN", 0, snoopMatchN);
    chk("snoopDirtyMatchN", 0, snoopDirtyMatchN);
    @(posedge ref_clk);
    wbCycleActive <= 1'b1;
    transferReadyN <= 1'b0;
    lastBeat <= 1'b1;
    @(posedge ref_clk);
    wbCycleActive <= 1'b0;
    transferReadyN <= 1'b1;
    #1;
    chk("snoopDirtyMatchN", 1, snoopDirtyMatchN);
    // A modified hit on a line already being written back asks for no new writeback.
    @(posedge ref_clk);
    snoopStrobeN <= 1'b0;
    lookupWbBusy <= 1'b1;
    @(posedge ref_clk);
    snoopStrobeN <= 1'b1;
    #1;
    chk("snoopDirtyMatchN", 0, snoopDirtyMatchN);
    chk("snoopWbReq", 0, snoopWbReq);
    $display("test inquire done");
    @(posedge ref_clk);
    doHold <= 1'b1;
    cycleInProgress <= 1'b1;
    lockSeqBusy <= 1'b1;
    lockMore <= 1'b1;
    cyc(4);
    #1;
    chk("holdAck", 0, holdAck);
    @(posedge ref_clk);
    transferReadyN <= 1'b0;
    lockMore <= 1'b0;
    @(posedge ref_clk);
    transferReadyN <= 1'b1;
    cycleInProgress <= 1'b0;
    lockSeqBusy <= 1'b0;
    #1;
    chk("holdAck", 1, holdAck);
    chk("busFloat", 1, busFloat);
    @(posedge ref_clk);
    doHold <= 1'b0;
    cyc(1);
    #1;
    chk("holdAck", 1, holdAck);
    cyc(1);
    #1;
    chk("holdAck", 0, holdAck);
    $display("test hold done");
    @(posedge ref_clk);
    doPurge <= 1'b1;
    @(posedge ref_clk);
    doPurge <= 1'b0;
    cyc(3);
    #1;
    chk("wbAllReq", 0, wbAllReq);
    boundary();
    chk("wbAllReq", 1, wbAllReq);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      doneV <= 3'(3'h1 << k);
      @(posedge ref_clk);
      doneV <= 3'h0;
      #1;
      chk("purge step", 3'(3'h2 << k), {fackReq, invalReq, wbAllReq});
    end
    $display("test purge done");
    axWrite(`CSS_OFS_CTRL, 32'h0000000F, resp);
    @(posedge ref_clk);
    doWarm <= 1'b1;
    @(posedge ref_clk);
    doWarm <= 1'b0;
    boundary();
    chk("restartTake", 1, restartTake);
    chk("restartFetchAddr", `CSS_RESET_START, restartFetchAddr);
    axRead(`CSS_OFS_CTRL, rd, resp);
    chk("ctrl", 32'h0000000C, rd);
    chk("noWritethroughBit", 1, noWritethroughBit);
    $display("test restart done");
    axWrite(`CSS_OFS_CTRL, 32'h00000002, resp);
    @(posedge ref_clk);
    doIrq <= 1'b1;
    @(posedge ref_clk);
    doIrq <= 1'b0;
    boundary();
    chk("iackReq", 1, iackReq);
    @(posedge ref_clk);
    iackDone <= 1'b1;
    iackVector <= 8'h5A;
    @(posedge ref_clk);
    iackDone <= 1'b0;
    #1;
    chk("isrJump", 1, isrJump);
    cyc(1);
    #1;
    chk("isrVector", 8'h5A, isrVector);
    chk("iackReq", 0, iackReq);
    $display("test interrupt done");
    @(posedge ref_clk);
    fpTargetValid <= 1'b1;
    fpExcPending <= 1'b1;
    fpErrSensitive <= 1'b1;
    cyc(2);
    #1;
    chk("fpStall", 1, fpStall);
    @(posedge ref_clk);
    ignoreNumericErrorN <= 1'b0;
    cyc(2);
    #1;
    chk("fpProceed", 1, fpProceed);
    @(posedge ref_clk);
    ignoreNumericErrorN <= 1'b1;
    nonmaskIrq <= 1'b1;
    cyc(2);
    #1;
    chk("fpIrqBreak", 1, fpIrqBreak);
    @(posedge ref_clk);
    nonmaskIrq <= 1'b0;
    axWrite(`CSS_OFS_CTRL, 32'h00000001, resp);
    cyc(2);
    #1;
    chk("fpVector10", 1, fpVector10);
    @(posedge ref_clk);
    fpErrSensitive <= 1'b0;
    cyc(2);
    #1;
    chk("fpProceed", 1, fpProceed);
    $display("test numeric done");
    @(posedge ref_clk);
    rst <= 1'b1;
    doPurge <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    doPurge <= 1'b0;
    #1;
    chk("floatTestMode", 1, floatTestMode);
    chk("snoopMatchOe", 0, snoopMatchOe);
    chk("holdAckOe", 0, holdAckOe);
    chk("snoopDirtyOe", 0, snoopDirtyOe);
    axRead(`CSS_OFS_STAT, rd, resp);
    chk("status", 32'h00000001, rd);
    $display("test strap done");
    conclude();
  end
endmodule // tb_top
